// >>> hw/dcop_pkg.sv
// Constants of the DC output and alarm policy block.
// Assumes a 32-bit register port with byte addresses.
package dcop_pkg;
    localparam int          ADDR_W       = 8;
    localparam int          DATA_W       = 32;
    localparam int          EVT_W        = 8;
    localparam int          IN_W         = 7;
    // Register byte addresses
    localparam logic [7:0]  ADDR_CTRL    = 8'h00;
    localparam logic [7:0]  ADDR_PINCFG  = 8'h04;
    localparam logic [7:0]  ADDR_STATUS  = 8'h08;
    localparam logic [7:0]  ADDR_INTSTAT = 8'h0c;
    localparam logic [7:0]  ADDR_INTMASK = 8'h10;
    // Control register fields
    localparam int          C_REM_ALLOW  = 0;
    localparam int          C_RANGE_10V  = 1;
    localparam int          C_SB_INV     = 2;
    localparam int          C_SB_ONOFF   = 3;
    localparam int          C_PWR_REST   = 4;
    localparam int          C_PF_AUTO    = 5;
    localparam int          C_REM_AUTO   = 6;
    localparam int          C_OT_AUTO    = 7;
    localparam int          C_SHARE_MST  = 8;
    localparam int          C_STAT_DC    = 9;
    localparam int          CTRL_W       = 10;
    localparam logic [9:0]  CTRL_RST     = 10'h001;
    // Pin routing fields
    localparam int          P_P1_OT      = 0;
    localparam int          P_P1_PF      = 1;
    localparam int          P_P2_OVP     = 2;
    localparam int          P_P2_OCP     = 3;
    localparam int          P_P2_OPP     = 4;
    localparam int          PIN_W        = 5;
    localparam logic [4:0]  PINCFG_RST   = 5'h07;
    // Synchronised input / alarm bit positions
    localparam int          A_OT         = 0;
    localparam int          A_PF         = 1;
    localparam int          A_OVP        = 2;
    localparam int          A_OCP        = 3;
    localparam int          A_OPP        = 4;
    localparam int          A_CV         = 5;
    localparam int          A_SB         = 6;
    localparam int          ALM_W        = 5;
    // Event bits above the five alarm rises
    localparam int          E_SB_CHG     = 5;
    localparam int          E_REM_EXIT   = 6;
    localparam int          E_AUTO_ON    = 7;
endpackage

// >>> hw/dcop_sync.sv
// Two-flop synchroniser for a bundle of level inputs.
// Assumes each bit is a slow level from outside the clock domain.
`timescale 1ns/1ps
`default_nettype none
module dcop_sync #(
    parameter int W = 1
) (
    input  wire logic         i_clk,
    input  wire logic         i_sys_rst,
    input  wire logic [W-1:0] i_async,
    output var  logic [W-1:0] o_sync
);
    logic [W-1:0] meta;

    // First stage feeds only the second stage
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            meta   <= '0;
            o_sync <= '0;
        end else begin
            meta   <= i_async;
            o_sync <= meta;
        end
    end
endmodule
`default_nettype wire

// >>> hw/dcop_policy.sv
// DC output control policy, alarm pin routing and remote standby handling.
// Assumes pins and alarms are asynchronous; requests come from same-clock logic.
// Function
// - Remote permission off makes all remote control attempts ignored.
// - Range setting selects 5 V or 10 V full scale for analog interface.
// - Remote standby input polarity defaults normal; inverted complements the input.
// - First alarm pin reports overtemp and power fail, each enabled separately.
// - Second alarm pin reports overvoltage by default; three sources enabled separately.
// - Status pin shows constant voltage mode, or DC output state when selected.
// - Remote standby controls DC output even without analog remote control.
// - Off-only action: standby toggle may only switch DC output off.
// - On/off action: standby release restores output if it was on before.
// - Power-up policy off gives output off; restore gives previous state.
// - After power fail, auto policy re-enables output only if previously on.
// - Leaving remote: off policy forces output off; auto keeps last state.
// - After overtemp, auto policy re-enables output once cooled, if previously on.
// - Share bus role defaults to slave; exactly one master per group.
// - Any alarm switches the DC output off immediately.
//
// Implementation choices: strobed register access and the address map.
`timescale 1ns/1ps
`default_nettype none
module dcop_policy (
    input  wire logic                  i_clk,
    input  wire logic                  i_sys_rst,
    input  wire logic [7:0]            i_addr,
    input  wire logic [31:0]           i_wr_data,
    input  wire logic                  i_wr,
    input  wire logic                  i_rd,
    output var  logic [31:0]           o_rd_data,
    input  wire logic                  i_overtemp_alarm,
    input  wire logic                  i_power_fail_alarm,
    input  wire logic                  i_overvoltage_alarm,
    input  wire logic                  i_overcurrent_alarm,
    input  wire logic                  i_overpower_alarm,
    input  wire logic                  i_const_voltage_mode,
    input  wire logic                  i_remote_standby_input,
    input  wire logic                  i_remote_req,
    input  wire logic                  i_remote_on,
    input  wire logic                  i_remote_off,
    input  wire logic                  i_local_on,
    input  wire logic                  i_local_off,
    input  wire logic                  i_boot_done,
    input  wire logic                  i_saved_dc_on,
    output var  logic                  o_dc_output_on,
    output var  logic                  o_alarm_pin1,
    output var  logic                  o_alarm_pin2,
    output var  logic                  o_status_pin,
    output var  logic                  o_range_10v,
    output var  logic                  o_share_master,
    output var  logic                  o_remote_mode,
    output var  logic                  o_irq
);
    import dcop_pkg::*;

    logic [dcop_pkg::CTRL_W-1:0] ctrl;
    logic [dcop_pkg::PIN_W-1:0]  pincfg;
    logic [dcop_pkg::EVT_W-1:0]  int_stat;
    logic [dcop_pkg::EVT_W-1:0]  int_mask;
    logic [dcop_pkg::EVT_W-1:0]  evt;
    logic [dcop_pkg::IN_W-1:0]   in_s;
    logic [dcop_pkg::ALM_W-1:0]  alm;
    logic [dcop_pkg::ALM_W-1:0]  alm_q;
    logic [dcop_pkg::ALM_W-1:0]  alm_rise;
    logic                        sb;
    logic                        sb_q;
    logic                        sb_rise;
    logic                        sb_fall;
    logic                        rem_q;
    logic                        rem_exit;
    logic                        pf_fall;
    logic                        ot_fall;
    logic                        any_alm;
    logic                        pf_was_on;
    logic                        ot_was_on;
    logic                        sb_was_on;
    logic                        pf_reen;
    logic                        ot_reen;
    logic                        sb_reen;
    logic                        off_req;
    logic                        on_req;
    logic                        blocked;
    logic                        next_dc_on;
    logic                        wr_ctrl;
    logic                        wr_pin;

    dcop_sync #(
        .W (IN_W)
    ) u_sync (
        .i_clk     (i_clk),
        .i_sys_rst (i_sys_rst),
        .i_async   ({i_remote_standby_input, i_const_voltage_mode, i_overpower_alarm,
                     i_overcurrent_alarm, i_overvoltage_alarm, i_power_fail_alarm,
                     i_overtemp_alarm}),
        .o_sync    (in_s)
    );

    assign alm      = in_s[ALM_W-1:0];
    assign sb       = in_s[A_SB] ^ ctrl[C_SB_INV];
    assign alm_rise = alm & ~alm_q;
    assign any_alm  = |alm;
    assign sb_rise  = sb & ~sb_q;
    assign sb_fall  = ~sb & sb_q;
    assign pf_fall  = ~alm[A_PF] & alm_q[A_PF];
    assign ot_fall  = ~alm[A_OT] & alm_q[A_OT];
    assign rem_exit = rem_q & ~o_remote_mode;
    assign wr_ctrl  = i_wr && (i_addr == ADDR_CTRL);
    assign wr_pin   = i_wr && (i_addr == ADDR_PINCFG);

    // Remote control needs permission; local control applies only while remote mode is off
    assign o_remote_mode = ctrl[C_REM_ALLOW] & i_remote_req;
    assign o_range_10v    = ctrl[C_RANGE_10V];
    assign o_share_master = ctrl[C_SHARE_MST];

    // Standby acts without analog remote, but still obeys permission
    assign blocked = any_alm | (sb & ctrl[C_REM_ALLOW]);
    assign off_req = (o_remote_mode ? i_remote_off : i_local_off);
    assign on_req  = (o_remote_mode ? i_remote_on : i_local_on);
    assign pf_reen = pf_fall & ctrl[C_PF_AUTO] & pf_was_on;
    assign ot_reen = ot_fall & ctrl[C_OT_AUTO] & ot_was_on;
    assign sb_reen = sb_fall & ctrl[C_REM_ALLOW] & ctrl[C_SB_ONOFF] & sb_was_on;

    // Off causes outrank every on cause, except that boot done outranks an off request
    always_comb begin
        next_dc_on = o_dc_output_on;
        if (|alm_rise) begin
            next_dc_on = 1'b0;
        end else if (sb_rise && ctrl[C_REM_ALLOW]) begin
            next_dc_on = 1'b0;
        end else if (rem_exit && !ctrl[C_REM_AUTO]) begin
            next_dc_on = 1'b0;
        end else if (i_boot_done) begin
            next_dc_on = ctrl[C_PWR_REST] & i_saved_dc_on & ~blocked;
        end else if (off_req) begin
            next_dc_on = 1'b0;
        end else if (!blocked && (on_req || pf_reen || ot_reen || sb_reen)) begin
            next_dc_on = 1'b1;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            o_dc_output_on <= 1'b0;
        end else begin
            o_dc_output_on <= next_dc_on;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            alm_q <= '0;
            sb_q  <= 1'b0;
            rem_q <= 1'b0;
        end else begin
            alm_q <= alm;
            sb_q  <= sb;
            rem_q <= o_remote_mode;
        end
    end

    // Output state captured at the moment each cause strikes
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            pf_was_on <= 1'b0;
            ot_was_on <= 1'b0;
            sb_was_on <= 1'b0;
        end else begin
            if (alm_rise[A_PF]) begin
                pf_was_on <= o_dc_output_on;
            end
            if (alm_rise[A_OT]) begin
                ot_was_on <= o_dc_output_on;
            end
            if (sb_rise) begin
                sb_was_on <= o_dc_output_on;
            end
        end
    end

    // Pins registered so glitches of the routing logic never reach them
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            o_alarm_pin1 <= 1'b0;
            o_alarm_pin2 <= 1'b0;
            o_status_pin <= 1'b0;
        end else begin
            o_alarm_pin1 <= (pincfg[P_P1_OT] & alm[A_OT])
                          | (pincfg[P_P1_PF] & alm[A_PF]);
            o_alarm_pin2 <= (pincfg[P_P2_OVP] & alm[A_OVP])
                          | (pincfg[P_P2_OCP] & alm[A_OCP])
                          | (pincfg[P_P2_OPP] & alm[A_OPP]);
            o_status_pin <= ctrl[C_STAT_DC] ? o_dc_output_on : in_s[A_CV];
        end
    end

    // Configuration; an empty pin selection is not a valid choice and is dropped
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            ctrl   <= CTRL_RST;
            pincfg <= PINCFG_RST;
        end else begin
            if (wr_ctrl) begin
                ctrl <= i_wr_data[CTRL_W-1:0];
            end
            if (wr_pin && (|i_wr_data[P_P1_PF:P_P1_OT])) begin
                pincfg[P_P1_PF:P_P1_OT] <= i_wr_data[P_P1_PF:P_P1_OT];
            end
            if (wr_pin && (|i_wr_data[P_P2_OPP:P_P2_OVP])) begin
                pincfg[P_P2_OPP:P_P2_OVP] <= i_wr_data[P_P2_OPP:P_P2_OVP];
            end
        end
    end

    assign evt = {pf_reen | ot_reen | sb_reen, rem_exit, sb_rise | sb_fall, alm_rise};

    // Sticky status: a new event wins over a write-one clear
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            int_stat <= '0;
            int_mask <= '0;
        end else begin
            if (i_wr && (i_addr == ADDR_INTSTAT)) begin
                int_stat <= (int_stat & ~i_wr_data[EVT_W-1:0]) | evt;
            end else begin
                int_stat <= int_stat | evt;
            end
            if (i_wr && (i_addr == ADDR_INTMASK)) begin
                int_mask <= i_wr_data[EVT_W-1:0];
            end
        end
    end

    assign o_irq = |(int_stat & int_mask);

    // Read data valid only in the cycle after the strobe
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            o_rd_data <= '0;
        end else if (i_rd) begin
            case (i_addr)
                ADDR_CTRL:    o_rd_data <= {{(DATA_W-CTRL_W){1'b0}}, ctrl};
                ADDR_PINCFG:  o_rd_data <= {{(DATA_W-PIN_W){1'b0}}, pincfg};
                ADDR_STATUS:  o_rd_data <= {23'h000000, sb, o_remote_mode,
                                            o_dc_output_on, in_s[A_CV], alm};
                ADDR_INTSTAT: o_rd_data <= {{(DATA_W-EVT_W){1'b0}}, int_stat};
                ADDR_INTMASK: o_rd_data <= {{(DATA_W-EVT_W){1'b0}}, int_mask};
                default:      o_rd_data <= '0;
            endcase
        end else begin
            o_rd_data <= '0;
        end
    end

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);

    sequence s_alarm_strikes;
        |alm_rise;
    endsequence

    sequence s_sb_release_on;
        sb_fall && ctrl[C_SB_ONOFF] && ctrl[C_REM_ALLOW] && sb_was_on
            && !any_alm && !(|alm_rise) && !off_req && !rem_exit && !i_boot_done;
    endsequence

    sequence s_pf_clears_auto;
        pf_fall && ctrl[C_PF_AUTO] && pf_was_on && !blocked && !(|alm_rise)
            && !off_req && !(sb_rise && ctrl[C_REM_ALLOW]) && !rem_exit && !i_boot_done;
    endsequence

    AST_REM_GATE: assert property (
        !ctrl[C_REM_ALLOW] && i_remote_on && !o_dc_output_on && !i_local_on
            && !pf_reen && !ot_reen && !i_boot_done |=> !o_dc_output_on)
        else $error("remote on accepted without permission");

    AST_RANGE: assert property (
        wr_ctrl |=> o_range_10v == $past(i_wr_data[C_RANGE_10V]))
        else $error("range select did not follow write");

    AST_ALARM_OFF: assert property (
        s_alarm_strikes |=> !o_dc_output_on [*2])
        else $error("output not off after alarm");

    AST_PIN1: assert property (
        ##1 o_alarm_pin1 == $past((pincfg[P_P1_OT] & alm[A_OT]) | (pincfg[P_P1_PF] & alm[A_PF])))
        else $error("pin one does not match enabled alarms");

    AST_PIN2_OVP: assert property (
        pincfg[P_P2_OVP] && alm[A_OVP] |=> o_alarm_pin2)
        else $error("pin two misses overvoltage");

    AST_STATUS: assert property (
        ctrl[C_STAT_DC] |=> o_status_pin == $past(o_dc_output_on))
        else $error("status pin does not show output state");

    AST_SB_OFF: assert property (
        sb_rise && ctrl[C_REM_ALLOW] |=> !o_dc_output_on)
        else $error("standby did not switch output off");

    AST_SB_NO_ON: assert property (
        sb_fall && !ctrl[C_SB_ONOFF] && !o_dc_output_on && !on_req && !pf_reen
            && !ot_reen && !i_boot_done |=> !o_dc_output_on)
        else $error("off-only standby switched output on");

    AST_SB_ON: assert property (
        s_sb_release_on |=> o_dc_output_on)
        else $error("standby release did not restore output");

    AST_PF_AUTO: assert property (
        s_pf_clears_auto |=> o_dc_output_on)
        else $error("power fail auto re-enable missing");

    AST_REM_EXIT: assert property (
        rem_exit && !ctrl[C_REM_AUTO] |=> !o_dc_output_on)
        else $error("leaving remote kept output on");

    AST_PWRUP_OFF: assert property (
        i_boot_done && !ctrl[C_PWR_REST] && !(|alm_rise) |=> !o_dc_output_on)
        else $error("power-up off policy left output on");

    AST_SB_POL: assert property (
        ctrl[C_SB_INV] == $past(ctrl[C_SB_INV]) && !$past(i_sys_rst)
            |-> sb_q == ($past(in_s[A_SB]) ^ ctrl[C_SB_INV]))
        else $error("standby polarity not applied");

    AST_SHARE_RST: assert property (
        $past(i_sys_rst) |-> !o_share_master)
        else $error("share role not slave after reset");
endmodule
`default_nettype wire

// >>> test/dcop_ctrl_model.sv
// Far-side model: analog interface controller, alarm sources and a peer unit.
// Assumes the bench calls set_lines; levels move only just after a rising edge.
`timescale 1ns/1ps
`default_nettype none
module dcop_ctrl_model (
    input  wire logic       i_clk,
    output var  logic [6:0] o_lines,
    output var  logic       o_peer_master
);
    import dcop_pkg::*;
    logic [6:0] next_lines;
    // Peer stays slave, so the block under test may be the single master
    assign o_peer_master = 1'b0;
    // Lines are driven only by the clocked process, so they have a single driver
    initial begin
        next_lines = 7'h00;
    end
    task automatic set_lines(input logic [6:0] v);
        next_lines = v;
    endtask
    // Levels change right after the edge, never racing it
    always @(posedge i_clk) begin
        o_lines <= next_lines;
    end
endmodule
`default_nettype wire

// >>> test/dcop_policy_tb_top.sv
// Self-checking bench for the DC output and alarm policy block.
// Assumes the far-side model in dcop_ctrl_model and a 25 MHz clock.
`timescale 1ns/1ps
`default_nettype none
module dcop_policy_tb_top;
    import dcop_pkg::*;
    logic        clk, rst, wr, rd, rreq, ron, roff, lon, loff, boot, saved;
    logic [7:0]  addr;
    logic [31:0] wdata, rdata;
    logic [6:0]  lines;
    logic        dc, pin1, pin2, stpin, r10v, mst, rmode, irq, peer;
    logic [4:0]  cfgs [4] = '{5'h07, 5'h1f, 5'h09, 5'h12};
    int          err_total, num_checks;

    dcop_policy u_dut (.i_clk(clk), .i_sys_rst(rst), .i_addr(addr), .i_wr_data(wdata),
        .i_wr(wr), .i_rd(rd), .o_rd_data(rdata), .i_overtemp_alarm(lines[A_OT]),
        .i_power_fail_alarm(lines[A_PF]), .i_overvoltage_alarm(lines[A_OVP]),
        .i_overcurrent_alarm(lines[A_OCP]), .i_overpower_alarm(lines[A_OPP]),
        .i_const_voltage_mode(lines[A_CV]), .i_remote_standby_input(lines[A_SB]),
        .i_remote_req(rreq), .i_remote_on(ron), .i_remote_off(roff), .i_local_on(lon),
        .i_local_off(loff), .i_boot_done(boot), .i_saved_dc_on(saved),
        .o_dc_output_on(dc), .o_alarm_pin1(pin1), .o_alarm_pin2(pin2),
        .o_status_pin(stpin), .o_range_10v(r10v), .o_share_master(mst),
        .o_remote_mode(rmode), .o_irq(irq));
    dcop_ctrl_model u_model (.i_clk(clk), .o_lines(lines), .o_peer_master(peer));

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic chk_w(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value at %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_b(input logic got, input logic exp);
        chk_w({31'h0, got}, {31'h0, exp});
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
        #1;
    endtask
    // Read data stands only in the cycle after the strobe
    task automatic rd_reg(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        chk_w(rdata, exp);
    endtask
    // 0 local on, 1 local off, 2 remote on, 3 remote off, 4 boot done
    task automatic pulse(input int k);
        @(posedge clk);
        case (k)
            0: lon <= 1'b1;
            1: loff <= 1'b1;
            2: ron <= 1'b1;
            3: roff <= 1'b1;
            default: boot <= 1'b1;
        endcase
        @(posedge clk);
        {lon, loff, ron, roff, boot} <= 5'h00;
        cyc(1);
    endtask
    // Model edge plus synchroniser and pin register, with margin
    task automatic set_in(input logic [6:0] v);
        u_model.set_lines(v);
        cyc(5);
    endtask
    task automatic wait_dc(input logic exp);
        int n;
        n = 0;
        while (dc !== exp && n < 20) begin
            cyc(1);
            n++;
        end
        chk_b(dc, exp);
        if (n == 20) wrap_up();
    endtask

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    // Hang guard for the whole run
    initial begin
        repeat (20000) @(posedge clk);
        err_total++;
        wrap_up();
    end
    initial begin
        {wr, rd, rreq, ron, roff, lon, loff, boot, saved} = 9'h000;
        addr = 8'h00;
        wdata = 32'h0;
        err_total = 0;
        num_checks = 0;
        rst = 1'b1;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        cyc(1);
        rd_reg(ADDR_CTRL, 32'h001);
        rd_reg(ADDR_PINCFG, 32'h007);
        rd_reg(ADDR_INTMASK, 32'h0);
        rd_reg(8'h20, 32'h0);
        chk_b(mst, 1'b0);
        chk_b(peer, 1'b0);
        wr_reg(ADDR_CTRL, 32'h103);
        chk_b(r10v, 1'b1);
        chk_b(mst, 1'b1);
        wr_reg(ADDR_CTRL, 32'h001);
        chk_b(r10v, 1'b0);
        $display("test reset and range done");
        foreach (cfgs[j]) begin
            wr_reg(ADDR_PINCFG, {27'h0, cfgs[j]});
            for (int i = 0; i < ALM_W; i++) begin
                set_in(7'(1 << i));
                chk_b(pin1, cfgs[j][i] && i < 2);
                chk_b(pin2, cfgs[j][i] && i >= 2);
            end
        end
        // Empty groups keep their old selection
        wr_reg(ADDR_PINCFG, 32'h0);
        rd_reg(ADDR_PINCFG, 32'h12);
        wr_reg(ADDR_PINCFG, 32'h01);
        rd_reg(ADDR_PINCFG, 32'h11);
        $display("test pin routing done");
        set_in(7'h20);
        chk_b(stpin, 1'b1);
        wr_reg(ADDR_CTRL, 32'h201);
        cyc(2);
        chk_b(stpin, 1'b0);
        pulse(0);
        cyc(1);
        chk_b(stpin, 1'b1);
        $display("test status pin done");
        wr_reg(ADDR_INTSTAT, 32'hff);
        wr_reg(ADDR_INTMASK, 32'h04);
        chk_b(irq, 1'b0);
        set_in(7'h04);
        chk_b(dc, 1'b0);
        chk_b(irq, 1'b1);
        rd_reg(ADDR_STATUS, 32'h004);
        rd_reg(ADDR_INTSTAT, 32'h04);
        wr_reg(ADDR_INTSTAT, 32'h04);
        chk_b(irq, 1'b0);
        set_in(7'h00);
        chk_b(dc, 1'b0);
        $display("test alarm off and interrupt done");
        for (int k = 0; k < 2; k++) begin
            wr_reg(ADDR_CTRL, (k == 1) ? 32'h021 : 32'h081);
            pulse(0);
            set_in(7'(1 << k));
            chk_b(dc, 1'b0);
            set_in(7'h00);
            wait_dc(1'b1);
            wr_reg(ADDR_CTRL, 32'h001);
            set_in(7'(1 << k));
            set_in(7'h00);
            chk_b(dc, 1'b0);
        end
        $display("test re-enable policy done");
        for (int k = 0; k < 4; k++) begin
            wr_reg(ADDR_CTRL, k[1] ? 32'h011 : 32'h001);
            @(posedge clk) saved <= k[0];
            pulse(0);
            pulse(4);
            chk_b(dc, k[1] & k[0]);
        end
        $display("test power-up policy done");
        // Permission goes first, so no remote session is left behind
        wr_reg(ADDR_CTRL, 32'h000);
        @(posedge clk) rreq <= 1'b1;
        cyc(1);
        chk_b(rmode, 1'b0);
        pulse(3);
        chk_b(dc, 1'b1);
        pulse(1);
        chk_b(dc, 1'b0);
        pulse(2);
        chk_b(dc, 1'b0);
        pulse(0);
        chk_b(dc, 1'b1);
        wr_reg(ADDR_CTRL, 32'h001);
        chk_b(rmode, 1'b1);
        pulse(3);
        chk_b(dc, 1'b0);
        pulse(2);
        chk_b(dc, 1'b1);
        @(posedge clk) rreq <= 1'b0;
        cyc(2);
        chk_b(dc, 1'b0);
        wr_reg(ADDR_CTRL, 32'h041);
        @(posedge clk) rreq <= 1'b1;
        pulse(2);
        @(posedge clk) rreq <= 1'b0;
        cyc(2);
        chk_b(dc, 1'b1);
        $display("test remote control done");
        // Analog remote stays inactive throughout
        for (int m = 0; m < 4; m++) begin
            wr_reg(ADDR_CTRL, 32'h001 | 32'(m << 2));
            set_in({m[0], 6'h00});
            pulse(0);
            set_in({~m[0], 6'h00});
            chk_b(dc, 1'b0);
            set_in({m[0], 6'h00});
            chk_b(dc, m[1]);
        end
        wr_reg(ADDR_INTMASK, 32'h20);
        chk_b(irq, 1'b1);
        wr_reg(ADDR_INTSTAT, 32'hff);
        chk_b(irq, 1'b0);
        $display("test remote standby done");
        wrap_up();
    end
endmodule
`default_nettype wire
